// ### core/sadc_pkg.sv
// sadc_pkg: constants and types for the 8-bit APPROXIMATION_SHIFT_REG converter control
// assumes: 40 MHz main clock, 8-bit processor register port
package sadc_pkg;
    localparam logic [15:0] SADC_ADDR_MODE = 16'hff80;
    localparam logic [15:0] SADC_ADDR_CHAN = 16'hff84;
    localparam logic [15:0] SADC_ADDR_RESULT = 16'hff86;
    localparam logic [7:0] SADC_MODE_RESET = 8'h00;
    localparam logic [7:0] SADC_CHAN_RESET = 8'h00;
    localparam int SADC_ENABLE_BIT = 7;
    localparam int SADC_TSEL_LSB = 3;
    localparam logic [7:0] SADC_MODE_MASK = 8'h00b8;
    localparam logic [7:0] SADC_CHAN_MASK = 8'h0007;
    localparam logic [2:0] SADC_CHAN_MAX = 3'h5;
    localparam logic [7:0] SADC_CLK_144 = 8'h0090;
    localparam logic [7:0] SADC_CLK_120 = 8'h0078;
    localparam logic [7:0] SADC_CLK_96 = 8'h0060;
    localparam logic [7:0] SADC_CLK_72 = 8'h0048;
    localparam logic [7:0] SADC_CLK_60 = 8'h003c;
    localparam logic [7:0] SADC_CLK_48 = 8'h0030;
    localparam int SADC_SAR_STEPS = 8;

    typedef enum logic [1:0] {SADC_IDLE, SADC_SAMPLE, SADC_DECIDE} sadc_state_t;

    // main clock periods for one conversion, from the time-select field
    function automatic logic [7:0] sadc_conv_clocks(input logic [2:0] sel);
        case (sel)
            3'h0: sadc_conv_clocks = SADC_CLK_144;
            3'h1: sadc_conv_clocks = SADC_CLK_120;
            3'h2: sadc_conv_clocks = SADC_CLK_96;
            3'h4: sadc_conv_clocks = SADC_CLK_72;
            3'h5: sadc_conv_clocks = SADC_CLK_60;
            3'h6: sadc_conv_clocks = SADC_CLK_48;
            default: sadc_conv_clocks = SADC_CLK_144;
        endcase
    endfunction : sadc_conv_clocks
endpackage : sadc_pkg

// ### core/sadc_step_if.sv
// sadc_step_if: timing strobes between step timer and sequencer
// assumes: one clock domain, clk_sys
`timescale 1ns/1ps
`default_nettype none
interface sadc_step_if;
    logic restart;
    logic [7:0] total;
    logic sampleDone;
    logic stepTick;
    modport timer (input restart, input total, output sampleDone, output stepTick);
    modport seq (output restart, output total, input sampleDone, input stepTick);
endinterface : sadc_step_if
`default_nettype wire

// ### core/sadc_step_timer.sv
// sadc_step_timer: splits a conversion into a sample period and eight decision steps
// assumes: a third of total and the rest divide evenly; total holds steady in a conversion
`timescale 1ns/1ps
`default_nettype none
module sadc_step_timer
    import sadc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // sequencer side
    sadc_step_if.timer step
);
    typedef struct packed {
        logic [7:0] cnt;
        logic sampling;
        logic sampleDone;
        logic stepTick;
    } sadc_tmr_t;

    sadc_tmr_t r;
    sadc_tmr_t next_r;
    logic [7:0] stepLen;
    logic [7:0] sampleLen;

    // a third of the time samples, the rest is eight equal decision steps
    // sequencer acts a cycle after each strobe, so sampling ends one count early
    always_comb begin
        stepLen = 8'((step.total - (step.total / 8'd3)) >> 3);
        sampleLen = 8'(step.total - (stepLen << 3));
        next_r = r;
        next_r.sampleDone = 1'b0;
        next_r.stepTick = 1'b0;
        if (step.restart) begin
            next_r.cnt = 8'h00;
            next_r.sampling = 1'b1;
        end else if (r.sampling && r.cnt == 8'(sampleLen - 8'd2)) begin
            next_r.cnt = 8'h00;
            next_r.sampling = 1'b0;
            next_r.sampleDone = 1'b1;
        end else if (!r.sampling && r.cnt == 8'(stepLen - 8'd1)) begin
            next_r.cnt = 8'h00;
            next_r.stepTick = 1'b1;
        end else begin
            next_r.cnt = 8'(r.cnt + 8'd1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign step.sampleDone = r.sampleDone;
    assign step.stepTick = r.stepTick;
endmodule : sadc_step_timer
`default_nettype wire

// ### core/sadc_control.sv
// sadc_control: 8-bit successive-approximation converter control, six inputs
// assumes: byte register port on the main clock; comparator and standby from outside
// Operation
// - three-bit channel field picks input 0 to 5; others prohibited
// - time field sets 144, 120, 96, 72, 60 or 48 clocks per conversion
// - enable bit 7 of mode register starts converting the chosen channel
// - sample a fixed period, then hold until all bits are decided
// - conversion starts with MSB set, tap at half reference
// - each lower bit trial set; kept when input is at or above tap
// - after bit 0, latch result and raise end-of-conversion request together
// - conversions repeat automatically while enable stays set
// - mode or channel write aborts conversion; restart if enabled
// - mode write with enable clear stops conversion at once
// - first result after enabling, and results after disabling, are undefined
// - reset loads mode and channel registers with zero; result undefined
// - standby halts the converter
// - result register is eight bits, read-only, read as a byte
// - result equals integer of input ratio times 256 plus one half
// - a result read coinciding with the update completes first
// - register write coinciding with the update wins; no update, no request
// - mode write leaves the end-of-conversion flag alone
`timescale 1ns/1ps
`default_nettype none
module sadc_control
    import sadc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // processor register port
    input wire logic [15:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // chip power state
    input wire logic standby,
    // analog front end
    input wire logic compHigh,
    output logic sampleEnable,
    output logic holdEnable,
    output logic [2:0] channelSelect,
    output logic [7:0] tapCode,
    // events
    output logic conversionEndIrq
);
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] chan;
        logic [2:0] chanSel;
        logic [7:0] result;
        logic [7:0] approximation_shift_reg;
        logic [2:0] bitIdx;
        sadc_state_t state;
        logic [7:0] rdata;
        logic irq;
        logic sample;
        logic hold;
        logic [1:0] compSync;
        logic [1:0] standbySync;
    } sadc_ctl_t;

    sadc_ctl_t r;
    sadc_ctl_t next_r;
    sadc_step_if step();

    sadc_step_timer u_timer (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .step(step)
    );

    logic modeWr;
    logic chanWr;
    logic cfgWr;
    logic enabled;
    logic halted;
    logic decision;
    logic [7:0] decided;

    always_comb begin
        modeWr = regWrite && regAddr == SADC_ADDR_MODE;
        chanWr = regWrite && regAddr == SADC_ADDR_CHAN;
        cfgWr = modeWr || chanWr;
        halted = r.standbySync[1];
        decision = r.compSync[1];
        next_r = r;
        next_r.compSync = {r.compSync[0], compHigh};
        next_r.standbySync = {r.standbySync[0], standby};
        next_r.irq = 1'b0;
        step.total = sadc_conv_clocks(r.mode[SADC_TSEL_LSB +: 3]);
        step.restart = 1'b0;
        // read returns present contents; a same-cycle update lands after
        case (regAddr)
            SADC_ADDR_MODE: next_r.rdata = r.mode;
            SADC_ADDR_CHAN: next_r.rdata = r.chan;
            SADC_ADDR_RESULT: next_r.rdata = r.result;
            default: next_r.rdata = 8'h00;
        endcase
        if (!regRead) begin
            next_r.rdata = r.rdata;
        end
        // write wins over the conversion; flag is elsewhere so untouched
        if (modeWr) begin
            next_r.mode = regWdata & SADC_MODE_MASK;
        end
        if (chanWr) begin
            next_r.chan = regWdata & SADC_CHAN_MASK;
        end
        // a prohibited channel code is clamped to the top channel
        next_r.chanSel = next_r.chan[2:0];
        if (next_r.chan[2:0] > SADC_CHAN_MAX) begin
            next_r.chanSel = SADC_CHAN_MAX;
        end
        enabled = next_r.mode[SADC_ENABLE_BIT];
        decided = r.approximation_shift_reg;
        if (!decision) begin
            decided[r.bitIdx] = 1'b0;
        end
        if (cfgWr || halted) begin
            // abort; a new session starts only if still enabled
            next_r.state = SADC_IDLE;
            next_r.sample = 1'b0;
            next_r.hold = 1'b0;
        end else begin
            case (r.state)
                SADC_IDLE: begin
                    if (enabled) begin
                        next_r.state = SADC_SAMPLE;
                        next_r.sample = 1'b1;
                        step.restart = 1'b1;
                    end
                end
                SADC_SAMPLE: begin
                    if (step.sampleDone) begin
                        next_r.state = SADC_DECIDE;
                        next_r.sample = 1'b0;
                        next_r.hold = 1'b1;
                        next_r.approximation_shift_reg = 8'h80;
                        next_r.bitIdx = 3'h7;
                    end
                end
                SADC_DECIDE: begin
                    if (step.stepTick) begin
                        if (r.bitIdx == 3'h0) begin
                            // back to sampling for the next round
                            next_r.result = decided;
                            next_r.irq = 1'b1;
                            next_r.approximation_shift_reg = decided;
                            next_r.hold = 1'b0;
                            next_r.state = SADC_SAMPLE;
                            next_r.sample = 1'b1;
                            step.restart = 1'b1;
                        end else begin
                            next_r.approximation_shift_reg = decided | (8'h01 << (r.bitIdx - 3'h1));
                            next_r.bitIdx = 3'(r.bitIdx - 3'h1);
                        end
                    end
                end
                default: begin
                    next_r.state = SADC_IDLE;
                end
            endcase
            if (!enabled) begin
                next_r.state = SADC_IDLE;
                next_r.sample = 1'b0;
                next_r.hold = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            r.mode <= SADC_MODE_RESET;
            r.chan <= SADC_CHAN_RESET;
            r.chanSel <= SADC_CHAN_RESET[2:0];
            r.result <= 8'h00;
            r.approximation_shift_reg <= 8'h00;
            r.bitIdx <= 3'h0;
            r.state <= SADC_IDLE;
            r.rdata <= 8'h00;
            r.irq <= 1'b0;
            r.sample <= 1'b0;
            r.hold <= 1'b0;
            r.compSync <= 2'h0;
            r.standbySync <= 2'h0;
        end else begin
            r <= next_r;
        end
    end

    assign channelSelect = r.chanSel;
    assign regRdata = r.rdata;
    assign sampleEnable = r.sample;
    assign holdEnable = r.hold;
    assign tapCode = r.approximation_shift_reg;
    assign conversionEndIrq = r.irq;
endmodule : sadc_control
`default_nettype wire

// ### sim/sadc_control_properties.sv
// sadc_control_properties: port-level checks of the converter control
// assumes: bound into sadc_control, one clock domain
`timescale 1ns/1ps
`default_nettype none
module sadc_control_properties
    import sadc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // register port
    input wire logic [15:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    // front end and events
    input wire logic standby,
    input wire logic sampleEnable,
    input wire logic holdEnable,
    input wire logic [2:0] channelSelect,
    input wire logic [7:0] tapCode,
    input wire logic conversionEndIrq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic modeWr;
    logic cfgWr;
    assign modeWr = regWrite && regAddr == SADC_ADDR_MODE;
    assign cfgWr = modeWr || (regWrite && regAddr == SADC_ADDR_CHAN);
    sequence s_idle; !sampleEnable && !holdEnable && !conversionEndIrq; endsequence
    // standby passes two sync flops before it bites
    sequence s_stby; standby [*4]; endsequence
    property p_chan; channelSelect <= SADC_CHAN_MAX; endproperty
    a_chan: assert property (p_chan) else $error("channel code above five");
    property p_excl; !(sampleEnable && holdEnable); endproperty
    a_excl: assert property (p_excl) else $error("sample and hold together");
    property p_msb; $rose(holdEnable) |-> tapCode == 8'h80; endproperty
    a_msb: assert property (p_msb) else $error("first tap not half scale");
    property p_step; holdEnable && $past(holdEnable) && tapCode != $past(tapCode)
        |-> $countones(tapCode ^ $past(tapCode)) inside {[1:2]}; endproperty
    a_step: assert property (p_step) else $error("tap moved by more than one step");
    property p_end; conversionEndIrq |-> $past(holdEnable); endproperty
    a_end: assert property (p_end) else $error("end pulse without hold phase");
    property p_pulse; conversionEndIrq |=> !conversionEndIrq; endproperty
    a_pulse: assert property (p_pulse) else $error("end pulse too long");
    property p_repeat; conversionEndIrq |-> sampleEnable; endproperty
    a_repeat: assert property (p_repeat) else $error("no automatic restart");
    property p_wins; cfgWr |=> !conversionEndIrq; endproperty
    a_wins: assert property (p_wins) else $error("end pulse beside a write");
    property p_stop; modeWr && !regWdata[7] |=> s_idle [*2]; endproperty
    a_stop: assert property (p_stop) else $error("disable did not stop");
    property p_stby; s_stby |=> s_idle; endproperty
    a_stby: assert property (p_stby) else $error("standby did not halt");
    property p_start; modeWr && regWdata[7] && !standby |-> ##[1:3] sampleEnable; endproperty
    a_start: assert property (p_start) else $error("enable did not start");
endmodule : sadc_control_properties
bind sadc_control sadc_control_properties u_props (.clk_sys(clk_sys), .rst_b(rst_b),
    .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata), .standby(standby),
    .sampleEnable(sampleEnable), .holdEnable(holdEnable), .channelSelect(channelSelect),
    .tapCode(tapCode), .conversionEndIrq(conversionEndIrq));
`default_nettype wire

// ### sim/sadc_analog_model.sv
// sadc_analog_model: sample-hold, tap string and comparator
// assumes: VIN holds one level per channel, channel 0 in the low byte
`timescale 1ns/1ps
`default_nettype none
module sadc_analog_model #(
    parameter logic [47:0] VIN = 48'h0000_0000_0000
) (
    // clock
    input wire logic clk_sys,
    // converter controls
    input wire logic sampleEnable,
    input wire logic holdEnable,
    input wire logic [2:0] channelSelect,
    input wire logic [7:0] tapCode,
    // decision
    output logic compHigh
);
    logic [7:0] held = 8'h00;
    logic noise = 1'b0;
    // outside hold the decision is meaningless, so it toggles
    always_ff @(posedge clk_sys) begin
        noise <= ~noise;
        if (sampleEnable) begin
            held <= VIN[channelSelect*8 +: 8];
        end
    end
    assign compHigh = holdEnable ? (held >= tapCode) : noise;
endmodule : sadc_analog_model
`default_nettype wire

// ### sim/sadc_control_tb_top.sv
// sadc_control_tb_top: register-level tests of the converter control
// assumes: analog model at the front end, 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module sadc_control_tb_top
    import sadc_pkg::*;
();
    localparam logic [47:0] VIN = 48'h5a01_7f80_ff00;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regWdata = 8'h00;
    logic standby = 1'b0;
    logic [7:0] regRdata, tapCode, d;
    logic [2:0] channelSelect;
    logic compHigh, sampleEnable, holdEnable, conversionEndIrq;
    logic [9:0] n;
    int n_errors = 0;
    int checked = 0;
    logic [2:0] tcode [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h4, 3'h4};
    logic [9:0] tclk [6] = '{10'h090, 10'h078, 10'h060, 10'h048, 10'h048, 10'h048};
    sadc_control dut (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
        .standby(standby), .compHigh(compHigh), .sampleEnable(sampleEnable),
        .holdEnable(holdEnable), .channelSelect(channelSelect), .tapCode(tapCode),
        .conversionEndIrq(conversionEndIrq));
    sadc_analog_model #(.VIN(VIN)) u_model (.clk_sys(clk_sys), .sampleEnable(sampleEnable),
        .holdEnable(holdEnable), .channelSelect(channelSelect), .tapCode(tapCode),
        .compHigh(compHigh));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask : rd
    // edges until the next end pulse, bounded
    task automatic wirq();
        n = 10'h000;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while (conversionEndIrq !== 1'b1 && n < 10'h190);
        if (n >= 10'h190) begin
            $display("ERROR t=%0t no end-of-conversion pulse", $time);
            n_errors++;
            give_verdict();
        end
    endtask : wirq
    task automatic quiet();
        repeat (300) begin
            @(posedge clk_sys);
            #1 chk({7'h00, conversionEndIrq, holdEnable, sampleEnable}, 10'h000);
        end
    endtask : quiet
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(SADC_ADDR_MODE);
        chk({2'b00, d}, {2'b00, SADC_MODE_RESET});
        rd(SADC_ADDR_CHAN);
        chk({2'b00, d}, {2'b00, SADC_CHAN_RESET});
        $display("test reset values done");
        for (int i = 0; i < 6; i++) begin
            wr(SADC_ADDR_CHAN, 8'(i));
            // reserved bits stay zero; no code reaches 14 us at this clock, so legal ones only
            wr(SADC_ADDR_MODE, {2'b10, tcode[i], 3'h0});
            wirq();
            wirq();
            chk(n, tclk[i]);
            rd(SADC_ADDR_RESULT);
            chk({2'b00, d}, {2'b00, VIN[i*8 +: 8]});
            $display("test channel %0d done", i);
        end
        repeat (30) @(posedge clk_sys);
        wr(SADC_ADDR_CHAN, 8'h00);
        wirq();
        chk({9'h000, n > 10'h040}, 10'h001);
        @(posedge clk_sys);
        standby <= 1'b1;
        repeat (4) @(posedge clk_sys);
        quiet();
        @(posedge clk_sys);
        standby <= 1'b0;
        wirq();
        wirq();
        chk(n, 10'h048);
        $display("test abort and standby done");
        wr(SADC_ADDR_MODE, 8'h20);
        quiet();
        rd(SADC_ADDR_RESULT);
        n = {2'b00, d};
        wr(SADC_ADDR_RESULT, ~d);
        rd(SADC_ADDR_RESULT);
        chk({2'b00, d}, n);
        $display("test disable done");
        give_verdict();
    end
endmodule : sadc_control_tb_top
`default_nettype wire
